// *** core/eec_fifo.sv ***
`timescale 1ns/1ps
module eec_fifo
  import eec_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // streams
  eec_stream_if.snk wrSide,
  eec_stream_if.src rdSide
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doPush;
  logic doPop;

  assign wrSide.ready = (count != FULL_COUNT);
  assign rdSide.valid = (count != '0);
  assign rdSide.data = store[rdPtr];
  assign doPush = wrSide.valid & wrSide.ready;
  assign doPop = rdSide.valid & rdSide.ready;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      store[wrPtr] <= wrSide.data;
    end
  end

  // ----------------------------------------
  // pointers and fill level
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : eec_fifo

// *** core/eec_pkg.sv ***
package eec_pkg;

  // ----------------------------------------
  // memory organisation
  // ----------------------------------------
  localparam int MEM_BYTES = 4096;
  localparam int ADDR_W = 12;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam int BASE_W = ADDR_W - PAGE_W;

  // ----------------------------------------
  // select byte decode
  // ----------------------------------------
  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_IDENT = 4'hB;
  localparam int SEL_TYPE_POS = 4;
  localparam int SEL_CS_POS = 1;
  localparam int SEL_DIR_POS = 0;

  // ----------------------------------------
  // bit counting on the link
  // ----------------------------------------
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // the clock fall that ends a start is not a bit: wraps to zero on it
  localparam logic [3:0] START_FALL = 4'hF;

  // ----------------------------------------
  // write buffer
  // ----------------------------------------
  localparam int FIFO_W = PAGE_W + 8;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------
  // self-timed programming
  // ----------------------------------------
  localparam longint WRITE_TIME_NS = 4000000;
  localparam longint CLK_PERIOD_NS = 25;
  localparam int WRITE_CYCLES = int'(WRITE_TIME_NS / CLK_PERIOD_NS);

  // ----------------------------------------
  // link states
  // ----------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_DEVSEL = 7'h02,
    ST_ADDRH  = 7'h04,
    ST_ADDRL  = 7'h08,
    ST_WDATA  = 7'h10,
    ST_RDATA  = 7'h20,
    ST_IGNORE = 7'h40
  } eec_state_t;

endpackage : eec_pkg

// *** core/eec_slave.sv ***
`timescale 1ns/1ps
module eec_slave
  import eec_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES,
  parameter bit IDENT_EN = 1'b1
) (
  // system
  input wire logic core_clk,
  input wire logic rst,
  // serial link
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // address and protect pins
  input wire logic chipSelectBit0,
  input wire logic chipSelectBit1,
  input wire logic chipSelectBit2,
  input wire logic wpPin,
  // configuration
  input wire logic cfgUnlocked,
  input wire logic identLockSet,
  // status
  output logic standby,
  output logic writeBusy,
  output logic identLocked
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  eec_state_t state;
  logic sclMeta, sclS, sclD;
  logic sdaMeta, sdaS, sdaD;
  logic wpMeta, wpS;
  logic [2:0] csMeta, csS;
  logic sclRise, sclFall, startDet, stopDet, byteDone, ackDone;
  logic [3:0] bitCnt;
  logic [7:0] rxShift, txShift, addrHi;
  logic [ADDR_W-1:0] ptr;
  logic [BASE_W-1:0] pageBase;
  logic identSel, progIdent, masterAck, newAddr;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] identMem [PAGE_BYTES], pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask;
  logic wroteData, commitReq, tmrStart, tmrBusy, tmrDone, busyAll, selOk;
  logic [PAGE_W-1:0] popIdx;

  eec_stream_if #(.W(FIFO_W)) pushIf ();
  eec_stream_if #(.W(FIFO_W)) popIf ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic sel_match(input logic [7:0] sel, input logic [2:0] cs, input logic identOn);
    logic typeOk;
    typeOk = (sel[7:SEL_TYPE_POS] == TYPE_MAIN) || (identOn && (sel[7:SEL_TYPE_POS] == TYPE_IDENT));
    return typeOk && (sel[SEL_CS_POS+2:SEL_CS_POS] == cs);
  endfunction : sel_match

  function automatic logic write_allowed(input logic toIdent, input logic locked, input logic wp,
                                         input logic unlocked);
    return toIdent ? !locked : (!wp || unlocked);
  endfunction : write_allowed

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // sampling margin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclMeta <= 1'b1;
      sclS <= 1'b1;
      sclD <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclMeta <= sclPin;
      sclS <= sclMeta;
      sclD <= sclS;
      sdaMeta <= sdaIn;
      sdaS <= sdaMeta;
      sdaD <= sdaS;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wpMeta <= 1'b0;
      wpS <= 1'b0;
      csMeta <= 3'h0;
      csS <= 3'h0;
    end else begin
      wpMeta <= wpPin;
      wpS <= wpMeta;
      csMeta <= {chipSelectBit2, chipSelectBit1, chipSelectBit0};
      csS <= csMeta;
    end
  end

  // ----------------------------------------
  // bus events
  // ----------------------------------------
  // bits timed by master clock
  assign sclRise = sclS & ~sclD;
  assign sclFall = ~sclS & sclD;
  assign startDet = sclS & sclD & sdaD & ~sdaS;
  assign stopDet = sclS & sclD & ~sdaD & sdaS;
  assign byteDone = sclFall && (bitCnt == LAST_DATA_BIT);
  assign ackDone = sclFall && (bitCnt == ACK_BIT);
  assign busyAll = tmrBusy | commitReq | tmrStart;
  assign selOk = sel_match(rxShift, csS, IDENT_EN) && !busyAll;
  assign newAddr = byteDone && (state == ST_ADDRL);

  // ----------------------------------------
  // write byte stream
  // ----------------------------------------
  assign pushIf.valid = byteDone && (state == ST_WDATA);
  assign pushIf.data = {ptr[PAGE_W-1:0], rxShift};
  assign popIf.ready = ~tmrBusy;
  assign popIdx = popIf.data[FIFO_W-1:8];

  eec_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) wrFifo (
    .core_clk(core_clk),
    .rst(rst),
    .wrSide(pushIf),
    .rdSide(popIf)
  );

  // ----------------------------------------
  // link state machine
  // ----------------------------------------
  // reset idles link
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      sdaOe <= 1'b0;
      addrHi <= 8'h00;
      ptr <= '0;
      pageBase <= '0;
      identSel <= 1'b0;
      masterAck <= 1'b0;
    end else if (startDet) begin
      state <= ST_DEVSEL;
      bitCnt <= START_FALL;
      sdaOe <= 1'b0;
    end else if (stopDet) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      sdaOe <= 1'b0;
    end else if (state != ST_IDLE) begin
      if (sclRise) begin
        if (bitCnt != ACK_BIT) begin
          rxShift <= {rxShift[6:0], sdaS};
        end else if (state == ST_RDATA) begin
          masterAck <= ~sdaS;
        end
      end
      if (byteDone) begin
        bitCnt <= ACK_BIT;
        sdaOe <= 1'b0;
        case (state)
          ST_DEVSEL: begin
            if (selOk) begin
              sdaOe <= 1'b1;
              identSel <= rxShift[SEL_TYPE_POS];
              masterAck <= 1'b1;
              state <= rxShift[SEL_DIR_POS] ? ST_RDATA : ST_ADDRH;
            end else begin
              state <= ST_IGNORE;
            end
          end
          ST_ADDRH: begin
            addrHi <= rxShift;
            sdaOe <= 1'b1;
            state <= ST_ADDRL;
          end
          ST_ADDRL: begin
            ptr <= {addrHi[ADDR_W-9:0], rxShift};
            pageBase <= {addrHi[ADDR_W-9:0], rxShift[7:PAGE_W]};
            sdaOe <= 1'b1;
            state <= ST_WDATA;
          end
          ST_WDATA: begin
            if (pushIf.ready) begin
              sdaOe <= 1'b1;
              ptr <= {ptr[ADDR_W-1:PAGE_W], ptr[PAGE_W-1:0] + 1'b1};
            end else begin
              state <= ST_IGNORE;
            end
          end
          ST_RDATA: begin
            ptr <= ptr + 1'b1;
          end
          default: begin
            state <= ST_IGNORE;
          end
        endcase
      end else if (ackDone) begin
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
        if (state == ST_RDATA) begin
          if (masterAck) begin
            sdaOe <= ~(identSel ? identMem[ptr[PAGE_W-1:0]][7] : mem[ptr][7]);
            txShift <= {(identSel ? identMem[ptr[PAGE_W-1:0]][6:0] : mem[ptr][6:0]), 1'b0};
          end else begin
            state <= ST_IGNORE;
          end
        end
      end else if (sclFall) begin
        bitCnt <= bitCnt + 1'b1;
        if (state == ST_RDATA) begin
          sdaOe <= ~txShift[7];
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // page collection and commit
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pageMask <= '0;
      wroteData <= 1'b0;
      commitReq <= 1'b0;
      tmrStart <= 1'b0;
      progIdent <= 1'b0;
    end else begin
      tmrStart <= 1'b0;
      if (newAddr) begin
        pageMask <= '0;
        wroteData <= 1'b0;
      end
      if (pushIf.valid && pushIf.ready) begin
        wroteData <= 1'b1;
      end
      if (popIf.valid && popIf.ready) begin
        pageMask[popIdx] <= 1'b1;
      end
      if (stopDet && wroteData) begin
        commitReq <= 1'b1;
        wroteData <= 1'b0;
      end
      if (commitReq && !popIf.valid) begin
        commitReq <= 1'b0;
        if (write_allowed(identSel, identLocked, wpS, cfgUnlocked) && (pageMask != '0)) begin
          tmrStart <= 1'b1;
          progIdent <= identSel;
        end else begin
          pageMask <= '0;
        end
      end
      if (tmrDone) begin
        pageMask <= '0;
      end
    end
  end

  // ----------------------------------------
  // programming timer
  // ----------------------------------------
  // self-timed cycle
  eec_wtimer #(.CYCLES(WRITE_CYCLES_P)) progTimer (
    .core_clk(core_clk),
    .rst(rst),
    .start(tmrStart),
    .busy(tmrBusy),
    .done(tmrDone)
  );

  // ----------------------------------------
  // storage arrays
  // ----------------------------------------
  // paged byte array
  always_ff @(posedge core_clk) begin
    if (popIf.valid && popIf.ready) begin
      pageBuf[popIdx] <= popIf.data[7:0];
    end
    if (tmrDone) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageMask[i]) begin
          if (progIdent) begin
            identMem[i] <= pageBuf[i];
          end else begin
            mem[{pageBase, PAGE_W'(i)}] <= pageBuf[i];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // lock flag
  // ----------------------------------------
  // sticky lock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      identLocked <= 1'b0;
    end else if (identLockSet) begin
      identLocked <= 1'b1;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  // standby waits for programming
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standby <= 1'b1;
      writeBusy <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      standby <= (state == ST_IDLE) && !busyAll && !wroteData;
      writeBusy <= busyAll;
      sdaOut <= 1'b0;
    end
  end

endmodule : eec_slave

// *** core/eec_stream_if.sv ***
`timescale 1ns/1ps
interface eec_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : eec_stream_if

// *** core/eec_wtimer.sv ***
`timescale 1ns/1ps
module eec_wtimer
  import eec_pkg::*;
#(
  parameter int CYCLES = WRITE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;

  // ----------------------------------------
  // programming interval
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt <= CW'(CYCLES - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
endmodule : eec_wtimer

// *** tb/eec_master.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// two-wire bus master model
// ----------------------------------------
module eec_master (
  // bus
  output logic scl,
  output logic pullLow,
  input wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  task automatic bitOut(input logic b);
    pullLow = ~b;
    #50 scl = 1'b1;
    #100 scl = 1'b0;
    #50;
  endtask : bitOut
  task automatic bitIn(output logic r);
    pullLow = 1'b0;
    #50 scl = 1'b1;
    #50 r = sdaLine;
    #50 scl = 1'b0;
    #50;
  endtask : bitIn
  task automatic start();
    pullLow = 1'b0;
    #50 scl = 1'b1;
    #100 pullLow = 1'b1;
    #100 scl = 1'b0;
    #50;
  endtask : start
  task automatic stop();
    pullLow = 1'b1;
    #50 scl = 1'b1;
    #100 pullLow = 1'b0;
    #100;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i]);
    end
    bitIn(r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bitIn(d[i]);
    end
    bitOut(last);
  endtask : rbyte
endmodule : eec_master

// *** tb/eec_slave_checker.sv ***
`timescale 1ns/1ps
module eec_slave_checker
  import eec_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  // system
  input wire logic core_clk,
  input wire logic rst,
  // link and config
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic identLockSet,
  // status
  input wire logic standby,
  input wire logic writeBusy,
  input wire logic identLocked
);
  localparam int BUSY_MAX = WRITE_CYCLES_P + 8;
  int busyCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busyCnt <= 0;
    end else if (writeBusy) begin
      busyCnt <= busyCnt + 1;
    end else begin
      busyCnt <= 0;
    end
  end
  sequence s_lockReq;
    identLockSet;
  endsequence
  sequence s_lockOn;
    ##[1:3] identLocked;
  endsequence
  a_reset_idle: assert property ($fell(rst) |-> standby && !writeBusy && !sdaOe && !identLocked)
    else $error("state after reset wrong");
  a_drive_low: assert property (!sdaOut)
    else $error("data line driven high");
  a_busy_no_ack: assert property (writeBusy |-> !sdaOe)
    else $error("line pulled while programming");
  a_busy_not_idle: assert property (writeBusy |-> !standby)
    else $error("standby while programming");
  a_oe_not_idle: assert property (sdaOe |-> !standby)
    else $error("standby while driving line");
  a_busy_bound: assert property (busyCnt <= BUSY_MAX)
    else $error("programming too long");
  a_lock_sets: assert property (s_lockReq |-> s_lockOn)
    else $error("lock not taken");
  a_lock_sticky: assert property (identLocked |=> identLocked)
    else $error("lock lost");
endmodule : eec_slave_checker
bind eec_slave eec_slave_checker #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (.core_clk(core_clk), .rst(rst),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .identLockSet(identLockSet), .standby(standby),
  .writeBusy(writeBusy), .identLocked(identLocked));

// *** tb/eec_slave_tb.sv ***
`timescale 1ns/1ps
module eec_slave_tb;
  import eec_pkg::*;
  localparam int WCYC = 400;
  logic coreClk, rst, wp, unlk, lockSet, k;
  logic [2:0] cs;
  logic [7:0] d;
  wire logic scl, mPull, sdaOe, sdaOut, standby, writeBusy, identLocked;
  wire logic sdaLine;
  int errors, checkCount;
  // ----------------------------------------
  // wired line with pull-up
  // ----------------------------------------
  assign sdaLine = ~(sdaOe | mPull);
  eec_slave #(.WRITE_CYCLES_P(WCYC), .IDENT_EN(1'b1)) DUT (.core_clk(coreClk), .rst(rst), .sclPin(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectBit0(cs[0]), .chipSelectBit1(cs[1]),
    .chipSelectBit2(cs[2]), .wpPin(wp), .cfgUnlocked(unlk), .identLockSet(lockSet), .standby(standby),
    .writeBusy(writeBusy), .identLocked(identLocked));
  eec_master master (.scl(scl), .pullLow(mPull), .sdaLine(sdaLine));
  initial begin
    coreClk = 1'b0;
    forever #12.5 coreClk = ~coreClk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic ok, input string msg);
    checkCount++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge coreClk);
  endtask : cyc
  task automatic waitIdle();
    int n;
    n = 0;
    while (writeBusy !== 1'b0 && n < WCYC + 100) begin
      @(posedge coreClk);
      n++;
    end
    if (n >= WCYC + 100) begin
      chk(1'b0, "programming never ended");
      end_of_test();
    end
    cyc(3);
  endtask : waitIdle
  task automatic addrw(input logic [3:0] ty, input logic [11:0] a, output logic ok);
    logic k0, k1, k2;
    master.start();
    master.wbyte({ty, cs, 1'b0}, k0);
    master.wbyte({4'h0, a[11:8]}, k1);
    master.wbyte(a[7:0], k2);
    ok = k0 & k1 & k2;
  endtask : addrw
  task automatic write1(input logic [3:0] ty, input logic [11:0] a, input logic [7:0] v);
    logic ok, kd;
    addrw(ty, a, ok);
    master.wbyte(v, kd);
    master.stop();
    chk(ok & kd, "write not acked");
  endtask : write1
  task automatic read1(input logic [3:0] ty, input logic [11:0] a, input logic [7:0] exp);
    logic ok, ks;
    logic [7:0] r;
    addrw(ty, a, ok);
    master.start();
    master.wbyte({ty, cs, 1'b1}, ks);
    master.rbyte(1'b1, r);
    master.stop();
    chk(ok & ks, "read not acked");
    chk(r === exp, "read data");
  endtask : read1
  task automatic probe(input logic [7:0] s, output logic ack);
    master.start();
    master.wbyte(s, ack);
    master.stop();
  endtask : probe
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write();
    write1(TYPE_MAIN, 12'h123, 8'h5A);
    cyc(8);
    chk(writeBusy === 1'b1 && standby === 1'b0, "not programming");
    probe({TYPE_MAIN, cs, 1'b0}, k);
    chk(k === 1'b0, "acked while busy");
    waitIdle();
    chk(standby === 1'b1, "no standby after write");
    read1(TYPE_MAIN, 12'h123, 8'h5A);
  endtask : t_write
  task automatic t_page();
    logic ok, k1, k2, k3;
    addrw(TYPE_MAIN, 12'h05F, ok);
    master.wbyte(8'h11, k1);
    master.wbyte(8'h22, k2);
    master.wbyte(8'h33, k3);
    master.stop();
    chk(ok & k1 & k2 & k3, "page bytes not acked");
    waitIdle();
    read1(TYPE_MAIN, 12'h05F, 8'h11);
    read1(TYPE_MAIN, 12'h040, 8'h22);
    read1(TYPE_MAIN, 12'h041, 8'h33);
  endtask : t_page
  task automatic t_protect();
    @(posedge coreClk) wp <= 1'b1;
    write1(TYPE_MAIN, 12'h123, 8'hA5);
    cyc(20);
    chk(writeBusy === 1'b0, "refused write still busy");
    read1(TYPE_MAIN, 12'h123, 8'h5A);
    @(posedge coreClk) unlk <= 1'b1;
    write1(TYPE_MAIN, 12'h123, 8'hA5);
    waitIdle();
    read1(TYPE_MAIN, 12'h123, 8'hA5);
    @(posedge coreClk) wp <= 1'b0;
    unlk <= 1'b0;
  endtask : t_protect
  task automatic t_select();
    for (int t = 0; t < 16; t++) begin
      probe({t[3:0], cs, 1'b0}, k);
      chk(k === (t == 10 || t == 11), "type decode");
    end
    for (int b = 0; b < 3; b++) begin
      probe({TYPE_MAIN, cs ^ (3'h1 << b), 1'b0}, k);
      chk(k === 1'b0, "foreign chip select acked");
    end
  endtask : t_select
  task automatic t_ident();
    write1(TYPE_IDENT, 12'h003, 8'h3C);
    waitIdle();
    read1(TYPE_IDENT, 12'h003, 8'h3C);
    @(posedge coreClk) lockSet <= 1'b1;
    @(posedge coreClk) lockSet <= 1'b0;
    cyc(3);
    chk(identLocked === 1'b1, "lock not set");
    write1(TYPE_IDENT, 12'h003, 8'hC3);
    cyc(20);
    chk(writeBusy === 1'b0, "locked write programs");
    read1(TYPE_IDENT, 12'h003, 8'h3C);
  endtask : t_ident
  task automatic t_abort();
    master.start();
    fork
      master.wbyte({TYPE_MAIN, cs, 1'b0}, k);
      begin
        cyc(70);
        chk(sdaOe === 1'b1, "no ack before reset");
        rst <= 1'b1;
        cyc(1);
        chk(sdaOe === 1'b0 && standby === 1'b1, "activity kept in reset");
      end
    join
    chk(k === 1'b1, "select not acked");
    master.stop();
    @(posedge coreClk) rst <= 1'b0;
    cyc(6);
    chk({standby, writeBusy, sdaOe, identLocked, sdaOut} === 5'b10000, "state after reset");
    read1(TYPE_MAIN, 12'h123, 8'hA5);
  endtask : t_abort
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    unlk = 1'b0;
    lockSet = 1'b0;
    cs = 3'h5;
    errors = 0;
    checkCount = 0;
    cyc(10);
    rst <= 1'b0;
    cyc(6);
    chk({standby, writeBusy, sdaOe, identLocked, sdaOut} === 5'b10000, "idle after reset");
    t_write();
    t_page();
    t_protect();
    t_select();
    t_ident();
    t_abort();
    end_of_test();
  end
endmodule : eec_slave_tb
